// File: src/dis_regs.svh
// Register offsets, field positions, reset values and codes for the ID block
`ifndef DIS_REGS_SVH
`define DIS_REGS_SVH
`define DIS_ADDR_PRODUCT_ID   8'h7A
`define DIS_ADDR_CONDITION    8'h7B
`define DIS_STAT_RESET        8'h00
`define DIS_SUPPLY_HI         7
`define DIS_SUPPLY_LO         6
`define DIS_BIT_INT_RESET     5
`define DIS_BIT_FACTORY       4
`define DIS_BIT_LOW_SUPPLY    3
`define DIS_BIT_UNUSED        2
`define DIS_BIT_SENSE_EN      1
`define DIS_BIT_OUTPUT_EN     0
`define DIS_SUPPLY_5V0        2'h0
`define DIS_SUPPLY_3V3        2'h1
`define DIS_SUPPLY_2V7        2'h2
`define DIS_SUPPLY_RSVD       2'h3
`define DIS_PRODUCT_CODE      8'h5A
`define DIS_RDATA_RESET       8'h00
`endif

// File: src/dis_pkg.sv
// Types shared by the identification and status block
package dis_pkg;
  typedef logic [7:0] dis_byte_t;
  typedef enum logic [1:0]
  {
    DIS_SUP_5V0  = 2'h0,
    DIS_SUP_3V3  = 2'h1,
    DIS_SUP_2V7  = 2'h2,
    DIS_SUP_RSVD = 2'h3
  } dis_supply_e;
  typedef struct packed
  {
    dis_supply_e supply_level_field;
    logic        internal_reset_flag;
    logic        factory_config_loaded_flag;
    logic        low_supply_flag;
    logic        unused_bit;
    logic        sensing_enabled_flag;
    logic        output_enabled_flag;
  } dis_status_s;
  typedef struct packed
  {
    logic      rd;
    logic      wr;
    dis_byte_t addr;
    dis_byte_t wdata;
  } dis_req_s;
endpackage

// File: src/dis_status_capture.sv
// Status capture: holds the condition bits seen by the host
`timescale 1ns/1ps
`include "dis_regs.svh"
module dis_status_capture
  import dis_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Hardware conditions
  input  wire logic [1:0]  supply_level_i,
  input  wire logic        int_reset_i,
  input  wire logic        factory_loaded_i,
  input  wire logic        low_supply_i,
  input  wire logic        sense_en_i,
  input  wire logic        output_en_i,
  // Captured status
  output dis_status_s      status_o
);
  dis_status_s status_q;
  dis_status_s status_d;

  always_comb
  begin
    status_d                            = dis_status_s'(`DIS_STAT_RESET);
    status_d.supply_level_field         = dis_supply_e'(supply_level_i);
    status_d.internal_reset_flag        = int_reset_i;
    status_d.factory_config_loaded_flag = factory_loaded_i;
    status_d.low_supply_flag            = low_supply_i;
    status_d.unused_bit                 = 1'b0;
    status_d.sensing_enabled_flag       = sense_en_i;
    status_d.output_enabled_flag        = output_en_i;
  end

  // All fields zero until detection lands one cycle after release
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      status_q <= dis_status_s'(`DIS_STAT_RESET);
    else
      status_q <= status_d;
  end

  assign status_o = status_q;
endmodule // dis_status_capture

// File: src/dis_id_status_regs.sv
// Identification and status registers of the button controller
//
// Function
// - Read-only 8-bit product code register at address 7Ah.
// - Read-only 8-bit status register at 7Bh, zero at reset.
// - Bits 7:6 give detected supply: 00 5V, 01 3.3V, 10 2.7V.
// - Bit 5 set when last system reset was internal.
// - Bit 4 set when factory defaults loaded, clear for user set.
// - Bit 3 flags supply too low; nonvolatile writes then blocked.
// - Bit 1 shows capacitive sensing enabled.
// - Bit 0 shows general-purpose output enabled.
`timescale 1ns/1ps
`include "dis_regs.svh"
module dis_id_status_regs
  import dis_pkg::*;
#(
  // Arbitrary neutral code, not a real product number
  parameter logic [7:0] PRODUCT_CODE = `DIS_PRODUCT_CODE
)
(
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // Register access from the serial port engine
  input  wire logic        REG_RD_I,
  input  wire logic        REG_WR_I,
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic [7:0]  REG_WDATA_I,
  output logic      [7:0]  REG_RDATA_O,
  output logic             REG_HIT_O,
  // Hardware conditions
  input  wire logic [1:0]  SUPPLY_LEVEL_I,
  input  wire logic        INT_RESET_I,
  input  wire logic        FACTORY_LOADED_I,
  input  wire logic        LOW_SUPPLY_I,
  input  wire logic        SENSE_EN_I,
  input  wire logic        OUTPUT_EN_I,
  // Nonvolatile write gating
  input  wire logic        NVM_WR_REQ_I,
  output logic             NVM_WR_GO_O,
  output logic             NVM_WR_BLOCKED_O
);
  dis_req_s    req;
  dis_status_s status;
  dis_byte_t   rdata_d;
  dis_byte_t   rdata_q;
  logic        hit_q;
  logic        go_q;
  logic        blk_q;
  wire logic   sel_id;
  wire logic   sel_stat;
  wire logic   hit_d;

  assign req = '{rd: REG_RD_I, wr: REG_WR_I, addr: REG_ADDR_I,
                 wdata: REG_WDATA_I};

  dis_status_capture u_cap
  (
    .clk_i            (CLK_I),
    .rst_i            (RST_I),
    .supply_level_i   (SUPPLY_LEVEL_I),
    .int_reset_i      (INT_RESET_I),
    .factory_loaded_i (FACTORY_LOADED_I),
    .low_supply_i     (LOW_SUPPLY_I),
    .sense_en_i       (SENSE_EN_I),
    .output_en_i      (OUTPUT_EN_I),
    .status_o         (status)
  );

  // Writes never reach storage: data bus is deliberately unused
  assign sel_id   = (req.addr == `DIS_ADDR_PRODUCT_ID);
  assign sel_stat = (req.addr == `DIS_ADDR_CONDITION);
  assign hit_d    = req.rd & (sel_id | sel_stat);

  always_comb
  begin
    if (!req.rd)
      rdata_d = rdata_q;
    else if (sel_id)
      rdata_d = PRODUCT_CODE;
    else if (sel_stat)
      rdata_d = dis_byte_t'(status);
    else
      rdata_d = `DIS_RDATA_RESET;
  end

  // Read data held until the next read
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      rdata_q <= `DIS_RDATA_RESET;
      hit_q   <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      hit_q   <= hit_d;
    end
  end

  // Blocked request dropped, not deferred; host must retry
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      go_q  <= 1'b0;
      blk_q <= 1'b0;
    end
    else
    begin
      go_q  <= NVM_WR_REQ_I & ~status.low_supply_flag;
      blk_q <= NVM_WR_REQ_I & status.low_supply_flag;
    end
  end

  assign REG_RDATA_O      = rdata_q;
  assign REG_HIT_O        = hit_q;
  assign NVM_WR_GO_O      = go_q;
  assign NVM_WR_BLOCKED_O = blk_q;
endmodule // dis_id_status_regs

// File: sim/dis_id_status_regs_props.sv
// Checker for the identification and status registers
`timescale 1ns/1ps
module dis_id_status_regs_props #(parameter logic [7:0] PRODUCT_CODE = 8'h5A)
(
  input wire logic       CLK_I, RST_I, REG_RD_I, REG_HIT_O, NVM_WR_REQ_I,
  input wire logic       NVM_WR_GO_O, NVM_WR_BLOCKED_O, LOW_SUPPLY_I,
  input wire logic       INT_RESET_I, FACTORY_LOADED_I, SENSE_EN_I,
  input wire logic       OUTPUT_EN_I,
  input wire logic [1:0] SUPPLY_LEVEL_I,
  input wire logic [7:0] REG_ADDR_I, REG_RDATA_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  wire id_rd = REG_RD_I && REG_ADDR_I == 8'h7A;
  wire st_rd = REG_RD_I && REG_ADDR_I == 8'h7B;
  wire [7:0] cond = {SUPPLY_LEVEL_I, INT_RESET_I, FACTORY_LOADED_I,
    LOW_SUPPLY_I, 1'b0, SENSE_EN_I, OUTPUT_EN_I};
  // Stable inputs hide the one-cycle capture delay
  a_status_value: assert property (st_rd && $stable(cond) &&
    !$past(RST_I) |=> REG_RDATA_O == $past(cond, 2)) else $error("bad status");
  a_status_hit: assert property (st_rd |=> REG_HIT_O)
    else $error("status read missed");
  a_id_value: assert property (id_rd |=> REG_HIT_O &&
    REG_RDATA_O == PRODUCT_CODE) else $error("id read wrong");
  a_miss_zero: assert property (REG_RD_I && !id_rd && !st_rd |=>
    !REG_HIT_O && REG_RDATA_O == 8'h00) else $error("unmapped read");
  a_rdata_holds: assert property (!REG_RD_I |=>
    $stable(REG_RDATA_O) && !REG_HIT_O) else $error("rdata moved");
  a_nvm_block: assert property (NVM_WR_REQ_I && LOW_SUPPLY_I &&
    $stable(LOW_SUPPLY_I) && !$past(RST_I) |=> NVM_WR_BLOCKED_O
    && !NVM_WR_GO_O) else $error("write not blocked");
  a_nvm_grant: assert property (NVM_WR_REQ_I && !LOW_SUPPLY_I &&
    $stable(LOW_SUPPLY_I) && !$past(RST_I) |=> NVM_WR_GO_O
    && !NVM_WR_BLOCKED_O) else $error("write not granted");
  a_nvm_quiet: assert property (!NVM_WR_REQ_I |=>
    !NVM_WR_GO_O && !NVM_WR_BLOCKED_O) else $error("stray nvm pulse");
  c_id: cover property (id_rd);
  c_block: cover property (NVM_WR_BLOCKED_O);
  c_grant: cover property (NVM_WR_GO_O);
endmodule // dis_id_status_regs_props
bind dis_id_status_regs dis_id_status_regs_props
  #(.PRODUCT_CODE(PRODUCT_CODE)) chk (.*);

// File: sim/dis_host.sv
// Host model issuing register accesses and store requests
`timescale 1ns/1ps
module dis_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic            rd_o, wr_o, nvm_o,
  output logic [7:0]      addr_o, wdata_o
);
  logic [7:0] seen;
  initial {rd_o, wr_o, nvm_o, addr_o, wdata_o} = '0;
  task acc(input logic w, input logic [7:0] a, d);
    @(posedge clk_i) #1 {rd_o, wr_o, addr_o, wdata_o} = {!w, w, a, d};
    // Idle address shows the inverse, never the last value
    @(posedge clk_i) #1 {rd_o, wr_o, addr_o, wdata_o} = {2'b00, ~a, ~d};
    seen = rdata_i;
  endtask
  task store(input logic chk);
    if (chk) acc(1'b0, 8'h7B, 8'h00);
    if (!chk || !seen[3])
    begin
      @(posedge clk_i) #1 nvm_o = 1'b1;
      @(posedge clk_i) #1 nvm_o = 1'b0;
    end
  endtask
endmodule // dis_host

// File: sim/dis_id_status_regs_test.sv
// Self-checking bench for the identification and status registers
`timescale 1ns/1ps
module dis_id_status_regs_test;
  logic        clk = 0, rst = 1, rd, wr, nvm, hit, go, blk, iss;
  logic [6:0]  cnd = '0;
  logic [7:0]  addr, wd, rdat, r;
  logic [31:0] seed = 32'hb5b7_1403;
  int          err_count = 0, n_checks = 0, cyc = 0;
  always #12.5 clk = ~clk;
  dis_host host (.clk_i(clk), .rdata_i(rdat), .rd_o(rd), .wr_o(wr),
    .nvm_o(nvm), .addr_o(addr), .wdata_o(wd));
  dis_id_status_regs uut (.CLK_I(clk), .RST_I(rst), .REG_RD_I(rd),
    .REG_WR_I(wr), .REG_ADDR_I(addr), .REG_WDATA_I(wd), .REG_RDATA_O(rdat),
    .REG_HIT_O(hit), .SUPPLY_LEVEL_I(cnd[6:5]), .INT_RESET_I(cnd[4]),
    .FACTORY_LOADED_I(cnd[3]), .LOW_SUPPLY_I(cnd[2]), .SENSE_EN_I(cnd[1]),
    .OUTPUT_EN_I(cnd[0]), .NVM_WR_REQ_I(nvm), .NVM_WR_GO_O(go),
    .NVM_WR_BLOCKED_O(blk));
  function logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function logic [7:0] stx(input logic [6:0] c);
    return {c[6:2], 1'b0, c[1:0]};
  endfunction
  task cmp(input string n, input logic [7:0] e, s);
    n_checks++;
    if (s !== e)
    begin
      $display("BAD %s exp %h got %h", n, e, s);
      err_count++;
    end
  endtask
  task summarize();
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Ceiling well above the 520 to 600 cycles the loop needs
  always @(posedge clk)
    if (++cyc > 5000)
    begin
      err_count++;
      summarize();
    end
  initial
  begin
    repeat (8) @(posedge clk);
    #1 rst = 0;
    repeat (40)
    begin
      @(posedge clk) #1 cnd = xs();
      host.acc(1'b0, 8'h7B, 8'h00);
      cmp("status", stx(cnd), host.seen);
      r = xs();
      host.acc(1'b1, {7'h3D, r[0]}, xs());
      host.acc(1'b0, 8'h7B, 8'h00);
      cmp("status after write", stx(cnd), host.seen);
      host.acc(1'b0, 8'h7A, 8'h00);
      cmp("id", 8'h5A, host.seen);
      r = xs();
      host.acc(1'b0, (r[7:1] == 7'h3D) ? 8'h00 : r, 8'h00);
      cmp("unmapped", 8'h00, host.seen);
      r = xs();
      iss = !r[0] || !cnd[2];
      host.store(r[0]);
      cmp("store", {6'h00, iss && !cnd[2], iss && cnd[2]}, {6'h00, go, blk});
    end
    summarize();
  end
endmodule // dis_id_status_regs_test
